/* include/uebc_pkg.sv */
// Shared constants and types for the endpoint buffer command block
package uebc_pkg;
  localparam int DW = 16;
  localparam logic [7:0] CMD_RESET   = 8'hf6;
  localparam logic [7:0] CMD_WR_LO   = 8'h01;
  localparam logic [7:0] CMD_WR_HI   = 8'h0f;
  localparam logic [7:0] CMD_RD_CTL  = 8'h10;
  localparam logic [7:0] CMD_RD_LO   = 8'h12;
  localparam logic [7:0] CMD_RD_HI   = 8'h1f;
  localparam logic [7:0] CMD_ST_LO   = 8'h50;
  localparam logic [7:0] CMD_ST_HI   = 8'h5f;
  localparam int ST_HALT   = 7;
  localparam int ST_FULL1  = 6;
  localparam int ST_FULL0  = 5;
  localparam int ST_TOGGLE = 4;
  localparam int ST_CLOB   = 3;
  localparam int ST_SETUP  = 2;
  localparam int ST_BANK   = 1;
  localparam logic [7:0] ST_RESET = 8'h00;
  localparam int ISO_MAX_BYTES  = 1023;
  localparam int BULK_MAX_BYTES = 32;
  localparam int PTR_STEP       = 2;
  localparam int DMA_FIRST_WORD = 1;
  localparam logic [3:0] ADR_CMD  = 4'h0;
  localparam logic [3:0] ADR_DATA = 4'h4;
  localparam logic [3:0] ADR_STAT = 4'h8;
  typedef enum logic [1:0] {
    UEBC_IDLE, UEBC_WRBUF, UEBC_RDBUF, UEBC_STAT
  } uebc_mode_t;
  // Data words needed for n payload bytes
  function automatic int uebc_words(input int n);
    return (n + 1) / 2;
  endfunction
endpackage

/* include/uebc_if.sv */
// Parallel command/data bus between processor and device end
`timescale 1ns/1ps
`default_nettype none
interface uebc_if;
  logic        sel;
  logic        wr;
  logic        rd;
  logic [15:0] wdata;
  logic [15:0] rdata;
  modport dev  (input sel, wr, rd, wdata, output rdata);
  modport proc (output sel, wr, rd, wdata, input rdata);
endinterface
`default_nettype wire

/* core/uebc_dev.sv */
// Device end: command decode, endpoint buffers, status words, DMA
//
// Decided for this implementation: the Wishbone register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module uebc_dev #(
  parameter int NEP       = 16,
  parameter int BUF_BYTES = uebc_pkg::BULK_MAX_BYTES
) (
  input  wire logic           clk_i,
  input  wire logic           rst_i,
  uebc_if.dev                 bus,
  input  wire logic [3:0]     ev_ep_i,
  input  wire logic           stall_set_i,
  input  wire logic           unstall_i,
  input  wire logic           setup_tok_i,
  input  wire logic           setup_clob_i,
  input  wire logic           full_set_i,
  input  wire logic           full_clr_i,
  input  wire logic           full_bank_i,
  input  wire logic           toggle_set_i,
  input  wire logic           toggle_val_i,
  input  wire logic [NEP-1:0] dbl_buf_i,
  input  wire logic [3:0]     dma_ep_i,
  input  wire logic           dma_start_i,
  input  wire logic           dma_wr_i,
  input  wire logic           dma_rd_i,
  input  wire logic [15:0]    dma_wdata_i,
  input  wire logic           transfer_end_strobe_i,
  output logic [15:0]         dma_rdata_o,
  output logic                dma_last_o,
  output logic                pkt_send_o,
  output logic [3:0]          pkt_ep_o,
  output logic                irq_clr_o,
  output logic [3:0]          irq_clr_ep_o
);
  import uebc_pkg::*;
  localparam int WORDS = uebc_words(BUF_BYTES) + 1;
  localparam int AW    = $clog2(WORDS);
  localparam int MW    = 4 + 1 + AW;
  localparam logic [AW-1:0] LAST_W = AW'(WORDS - 1);
  localparam logic [AW-1:0] DMA_W0 = AW'(DMA_FIRST_WORD);
  localparam logic [AW:0]   STEP   = (AW+1)'(PTR_STEP);

  function automatic logic [MW-1:0] maddr(input logic [3:0] e,
                                          input logic b,
                                          input logic [AW-1:0] w);
    return {e, b, w};
  endfunction
  function automatic logic [15:0] wcount(input logic [15:0] n);
    return 16'((17'(n) + 17'd1) >> 1);
  endfunction

  logic [15:0]   mem [2**MW];
  uebc_mode_t    mode_reg;
  logic [3:0]    ep_reg;
  logic [AW:0]   ptr_reg;
  logic [15:0]   len_reg;
  logic [15:0]   rdata_reg;
  logic          soft_reg;
  logic [AW-1:0] dword_reg;
  logic          dbank_reg;
  logic [15:0]   dma_rdata_reg;
  logic          dma_last_reg;
  logic          send_reg;
  logic [3:0]    send_ep_reg;
  logic          clr_reg;
  logic [3:0]    clr_ep_reg;
  logic [NEP-1:0] halt_reg, full0_reg, full1_reg, tog_reg;
  logic [NEP-1:0] clob_reg, setup_reg, bank_reg;

  wire logic          srst    = rst_i || soft_reg;
  wire logic          cmd_wr  = bus.wr && bus.sel;
  wire logic          dat_wr  = bus.wr && !bus.sel;
  wire logic          dat_rd  = bus.rd && !bus.sel;
  wire logic [7:0]    code    = bus.wdata[7:0];
  wire logic          is_wr   = code >= CMD_WR_LO && code <= CMD_WR_HI;
  wire logic          is_rd   = code == CMD_RD_CTL ||
                                (code >= CMD_RD_LO && code <= CMD_RD_HI);
  wire logic          is_st   = code >= CMD_ST_LO && code <= CMD_ST_HI;
  wire logic [AW-1:0] cw      = ptr_reg[AW:1];
  wire logic          cbank   = bank_reg[ep_reg];
  wire logic          cpu_wr  = dat_wr && mode_reg == UEBC_WRBUF;
  wire logic          cpu_rd  = dat_rd && mode_reg == UEBC_RDBUF;
  wire logic          st_rd   = dat_rd && mode_reg == UEBC_STAT;
  wire logic [15:0]   cw_ext  = 16'(cw);
  wire logic          fill    = cpu_wr && cw != '0 &&
                                cw_ext == wcount(len_reg);
  wire logic [15:0]   dlen    = mem[maddr(dma_ep_i, dbank_reg, '0)];
  wire logic          dma_end = dword_reg == LAST_W;
  wire logic          dma_fill = dma_wr_i && dma_end;
  wire logic          send    = fill || dma_fill ||
                                transfer_end_strobe_i;
  wire logic [3:0]    send_ep = fill ? ep_reg : dma_ep_i;
  wire logic          send_bk = fill ? cbank : dbank_reg;
  wire logic [7:0]    st_word = {halt_reg[ep_reg], full1_reg[ep_reg],
                                 full0_reg[ep_reg], tog_reg[ep_reg],
                                 clob_reg[ep_reg], setup_reg[ep_reg],
                                 bank_reg[ep_reg], 1'b0};

  // Soft reset pulse lasts one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) soft_reg <= 1'b0;
    else soft_reg <= cmd_wr && code == CMD_RESET && !soft_reg;
  end

  // Buffer storage, no reset by design
  always_ff @(posedge clk_i) begin
    if (cpu_wr) mem[maddr(ep_reg, cbank, cw)] <= bus.wdata;
    if (dma_wr_i) mem[maddr(dma_ep_i, dbank_reg, dword_reg)] <= dma_wdata_i;
  end

  // Processor side command and pointer
  always_ff @(posedge clk_i) begin
    if (srst) begin
      mode_reg  <= UEBC_IDLE;
      ep_reg    <= '0;
      ptr_reg   <= '0;
      len_reg   <= '0;
      rdata_reg <= '0;
    end else if (cmd_wr) begin
      mode_reg <= is_wr ? UEBC_WRBUF : is_rd ? UEBC_RDBUF :
                  is_st ? UEBC_STAT : UEBC_IDLE;
      ep_reg   <= code[3:0];
      ptr_reg  <= '0;
    end else if (cpu_wr) begin
      if (cw == '0) len_reg <= bus.wdata;
      ptr_reg <= ptr_reg + STEP;
    end else if (cpu_rd) begin
      rdata_reg <= mem[maddr(ep_reg, cbank, cw)];
      ptr_reg   <= ptr_reg + STEP;
    end else if (st_rd) begin
      rdata_reg <= {8'h00, st_word};
    end
  end

  // DMA pointer skips the length word
  always_ff @(posedge clk_i) begin
    if (srst) begin
      dword_reg     <= DMA_W0;
      dbank_reg     <= 1'b0;
      dma_rdata_reg <= '0;
      dma_last_reg  <= 1'b0;
    end else if (dma_start_i) begin
      dword_reg <= DMA_W0;
      dbank_reg <= bank_reg[dma_ep_i];
    end else if (dma_wr_i || dma_rd_i) begin
      if (dma_rd_i) begin
        dma_rdata_reg <= mem[maddr(dma_ep_i, dbank_reg, dword_reg)];
        dma_last_reg  <= 16'(dword_reg) == wcount(dlen);
      end
      if (dma_end && dbl_buf_i[dma_ep_i] && !dbank_reg) begin
        dbank_reg <= 1'b1;
        dword_reg <= DMA_W0;
      end else if (!dma_end) begin
        dword_reg <= dword_reg + 1'b1;
      end
    end
  end

  // One-cycle notifications
  always_ff @(posedge clk_i) begin
    if (srst) begin
      send_reg    <= 1'b0;
      send_ep_reg <= '0;
      clr_reg     <= 1'b0;
      clr_ep_reg  <= '0;
    end else begin
      send_reg    <= send;
      send_ep_reg <= send_ep;
      clr_reg     <= st_rd;
      clr_ep_reg  <= ep_reg;
    end
  end

  // Per-endpoint status flags, set beats clear
  always_ff @(posedge clk_i) begin
    if (srst) begin
      {halt_reg, full0_reg, full1_reg, tog_reg} <= '0;
      {clob_reg, setup_reg, bank_reg} <= '0;
    end else begin
      for (int e = 0; e < NEP; e++) begin
        if (ev_ep_i == 4'(e) && stall_set_i) halt_reg[e] <= 1'b1;
        else if (ev_ep_i == 4'(e) && (unstall_i || setup_tok_i))
          halt_reg[e] <= 1'b0;
        if ((send && send_ep == 4'(e) && !send_bk) ||
            (full_set_i && ev_ep_i == 4'(e) && !full_bank_i))
          full0_reg[e] <= 1'b1;
        else if (full_clr_i && ev_ep_i == 4'(e) && !full_bank_i)
          full0_reg[e] <= 1'b0;
        if ((send && send_ep == 4'(e) && send_bk) ||
            (full_set_i && ev_ep_i == 4'(e) && full_bank_i))
          full1_reg[e] <= 1'b1;
        else if (full_clr_i && ev_ep_i == 4'(e) && full_bank_i)
          full1_reg[e] <= 1'b0;
        if (toggle_set_i && ev_ep_i == 4'(e))
          tog_reg[e] <= toggle_val_i;
        if (setup_clob_i && ev_ep_i == 4'(e)) clob_reg[e] <= 1'b1;
        else if (st_rd && ep_reg == 4'(e) && setup_reg[e])
          clob_reg[e] <= 1'b0;
        if (setup_tok_i && ev_ep_i == 4'(e)) setup_reg[e] <= 1'b1;
        else if (full_clr_i && ev_ep_i == 4'(e)) setup_reg[e] <= 1'b0;
        if (send && send_ep == 4'(e) && dbl_buf_i[e])
          bank_reg[e] <= ~bank_reg[e];
      end
    end
  end

  assign bus.rdata    = rdata_reg;
  assign dma_rdata_o  = dma_rdata_reg;
  assign dma_last_o   = dma_last_reg;
  assign pkt_send_o   = send_reg;
  assign pkt_ep_o     = send_ep_reg;
  assign irq_clr_o    = clr_reg;
  assign irq_clr_ep_o = clr_ep_reg;
endmodule // uebc_dev
`default_nettype wire

/* core/uebc_host.sv */
// Processor end: Wishbone registers driving the command/data bus
`timescale 1ns/1ps
`default_nettype none
module uebc_host #(
  parameter int MAX_WORDS = uebc_pkg::uebc_words(uebc_pkg::BULK_MAX_BYTES) + 1
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  uebc_if.proc             bus
);
  import uebc_pkg::*;
  typedef enum logic [1:0] {UEBC_H_IDLE, UEBC_H_RD1, UEBC_H_RD2} uebc_hst_t;
  localparam logic [7:0] MAXW = 8'(MAX_WORDS);

  uebc_hst_t   st_reg;
  uebc_mode_t  dir_reg;
  logic [7:0]  cnt_reg;
  logic        ack_reg;
  logic [31:0] dat_reg;
  logic        sel_reg, wr_reg, rd_reg;
  logic [15:0] wd_reg;

  wire logic       req    = wb_cyc_i && wb_stb_i && !ack_reg &&
                            st_reg == UEBC_H_IDLE;
  wire logic [7:0] code   = wb_dat_i[7:0];
  wire logic       c_wr   = code >= CMD_WR_LO && code <= CMD_WR_HI;
  wire logic       c_rd   = code == CMD_RD_CTL ||
                            (code >= CMD_RD_LO && code <= CMD_RD_HI);
  wire logic       c_st   = code >= CMD_ST_LO && code <= CMD_ST_HI;
  wire logic       room   = cnt_reg < MAXW;
  wire logic       do_cmd = req && wb_we_i && wb_adr_i == ADR_CMD &&
                            wb_sel_i[0];
  wire logic       do_wr  = req && wb_we_i && wb_adr_i == ADR_DATA &&
                            dir_reg == UEBC_WRBUF && room;
  wire logic       do_rd  = req && !wb_we_i && wb_adr_i == ADR_DATA &&
                            (dir_reg == UEBC_RDBUF ||
                             dir_reg == UEBC_STAT) && room;
  wire logic       quick  = req && !do_rd;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_reg  <= UEBC_H_IDLE;
      dir_reg <= UEBC_IDLE;
      cnt_reg <= '0;
      ack_reg <= 1'b0;
      dat_reg <= '0;
      sel_reg <= 1'b0;
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      wd_reg  <= '0;
    end else begin
      ack_reg <= 1'b0;
      wr_reg  <= 1'b0;
      rd_reg  <= 1'b0;
      if (do_cmd) begin
        sel_reg <= 1'b1;
        wr_reg  <= 1'b1;
        wd_reg  <= {8'h00, code};
        cnt_reg <= '0;
        dir_reg <= c_wr ? UEBC_WRBUF : c_rd ? UEBC_RDBUF :
                   c_st ? UEBC_STAT : UEBC_IDLE;
      end else if (do_wr) begin
        sel_reg <= 1'b0;
        wr_reg  <= 1'b1;
        wd_reg  <= wb_dat_i[15:0];
        cnt_reg <= cnt_reg + 8'h01;
      end
      if (quick) begin
        ack_reg <= 1'b1;
        dat_reg <= (!wb_we_i && wb_adr_i == ADR_STAT) ?
                   {22'h0, dir_reg, cnt_reg} : 32'h0;
      end
      unique case (st_reg)
        UEBC_H_IDLE: begin
          if (do_rd) begin
            sel_reg <= 1'b0;
            rd_reg  <= 1'b1;
            cnt_reg <= cnt_reg + 8'h01;
            st_reg  <= UEBC_H_RD1;
          end
        end
        UEBC_H_RD1: st_reg <= UEBC_H_RD2;
        UEBC_H_RD2: begin
          dat_reg <= {16'h0, bus.rdata};
          ack_reg <= 1'b1;
          st_reg  <= UEBC_H_IDLE;
        end
      endcase
    end
  end

  assign wb_dat_o  = dat_reg;
  assign wb_ack_o  = ack_reg;
  assign bus.sel   = sel_reg;
  assign bus.wr    = wr_reg;
  assign bus.rd    = rd_reg;
  assign bus.wdata = wd_reg;
endmodule // uebc_host
`default_nettype wire

/* testbench/uebc_asserts.sv */
// Checker for the shared command/data bus and device side effects
`timescale 1ns/1ps
`default_nettype none
module uebc_asserts
  import uebc_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sel,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [15:0] wdata,
  input wire logic [15:0] rdata,
  input wire logic        pkt_send_o,
  input wire logic        irq_clr_o,
  input wire logic [3:0]  irq_clr_ep_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [7:0]  cmd_reg;
  logic [7:0]  cnt_reg;
  logic [15:0] len_reg;
  wire logic   cmd_w = wr && sel;
  wire logic   dat_w = wr && !sel;
  wire logic   is_f6 = cmd_w && (wdata[7:0] == CMD_RESET);
  wire logic   st_md = (cmd_reg >= CMD_ST_LO) && (cmd_reg <= CMD_ST_HI);
  wire logic   wr_md = (cmd_reg >= CMD_WR_LO) && (cmd_reg <= CMD_WR_HI);
  wire logic   last_w = dat_w && wr_md && (cnt_reg != 8'h00)
                      && ({8'h00, cnt_reg} == (len_reg + 16'h0001) >> 1);
  // Word index since the last command
  always_ff @(posedge clk_i) begin
    if (rst_i || cmd_w) begin
      cnt_reg <= 8'h00;
    end else if (dat_w) begin
      cnt_reg <= cnt_reg + 8'h01;
    end
  end
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmd_reg <= 8'h00;
    end else if (cmd_w) begin
      cmd_reg <= wdata[7:0];
    end
  end
  always_ff @(posedge clk_i) begin
    if (dat_w && (cnt_reg == 8'h00)) begin
      len_reg <= wdata;
    end
  end
  property p_rd_data; rd |-> !sel; endproperty
  a_rd_data: assert property (p_rd_data)
    else $error("read strobe in command phase");
  property p_wr_pulse; wr |=> !wr; endproperty
  a_wr_pulse: assert property (p_wr_pulse)
    else $error("write strobe longer than one cycle");
  property p_wdata_hold; !$stable(wdata) |-> wr || rd; endproperty
  a_wdata_hold: assert property (p_wdata_hold)
    else $error("bus data moved without a strobe");
  property p_rdata_src;
    !$stable(rdata) |-> $past(rd) || $past(is_f6) || $past(is_f6, 2)
      || $past(is_f6, 3);
  endproperty
  a_rdata_src: assert property (p_rdata_src)
    else $error("read data moved without a read");
  property p_st_upper; rd && st_md |=> rdata[15:8] == 8'h00; endproperty
  a_st_upper: assert property (p_st_upper)
    else $error("status word upper byte not zero");
  property p_irq_clr;
    rd && st_md |-> ##[1:3] irq_clr_o && (irq_clr_ep_o == cmd_reg[3:0]);
  endproperty
  a_irq_clr: assert property (p_irq_clr)
    else $error("status read did not clear its interrupt");
  property p_pkt_send; last_w |-> ##[1:3] pkt_send_o; endproperty
  a_pkt_send: assert property (p_pkt_send)
    else $error("filled buffer not sent");
  property p_f6; is_f6 |-> ##[2:5] rdata == 16'h0000; endproperty
  a_f6: assert property (p_f6)
    else $error("soft reset left read data");
  cover property (rd && st_md);
  cover property (last_w);
  cover property (is_f6);
endmodule // uebc_asserts
`default_nettype wire

/* testbench/uebc_bench.sv */
// Bench joining both ends, with a word model of the buffers
`timescale 1ns/1ps
`default_nettype none
module uebc_bench;
  import uebc_pkg::*;
  logic        clk_i, ack, dma_last, pkt, irq;
  logic        rst_i = 1'b1, cyc = 1'b0, stb = 1'b0, we = 1'b0, fb = 1'b0;
  logic [3:0]  adr = 4'h0, dma_ep = 4'h0, sl = 4'h0, ee = 4'h0, pkt_ep, irq_ep;
  logic [3:0]  last_ep, clr_ep;
  logic [31:0] dat = 32'h0, rdat, q;
  logic [7:0]  evp = 8'h00;
  logic [2:0]  dp = 3'h0;
  logic [15:0] dma_wd = 16'h0000, dma_rdat, mk, dbl = 16'h0000;
  logic [15:0] mem [16][17];
  int          num_errors = 0, checks_done = 0, seed = 395, nw, pkts = 0;
  int          irqs = 0;
  uebc_if bus ();
  uebc_host uebc_host_i (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sl),
    .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack), .bus(bus));
  uebc_dev uebc_dev_i (.clk_i(clk_i), .rst_i(rst_i), .bus(bus),
    .ev_ep_i(ee), .stall_set_i(evp[0]), .unstall_i(evp[1]),
    .setup_tok_i(evp[2]), .setup_clob_i(evp[3]), .full_set_i(evp[4]),
    .full_clr_i(evp[5]), .full_bank_i(fb), .toggle_set_i(evp[6]),
    .toggle_val_i(fb), .dbl_buf_i(dbl), .dma_ep_i(dma_ep),
    .dma_start_i(dp[0]), .dma_wr_i(dp[1]), .dma_rd_i(dp[2]),
    .dma_wdata_i(dma_wd), .transfer_end_strobe_i(evp[7]),
    .dma_rdata_o(dma_rdat), .dma_last_o(dma_last), .pkt_send_o(pkt),
    .pkt_ep_o(pkt_ep), .irq_clr_o(irq), .irq_clr_ep_o(irq_ep));
  uebc_asserts uebc_asserts_i (.clk_i(clk_i), .rst_i(rst_i),
    .sel(bus.sel), .wr(bus.wr), .rd(bus.rd), .wdata(bus.wdata),
    .rdata(bus.rdata), .pkt_send_o(pkt), .irq_clr_o(irq),
    .irq_clr_ep_o(irq_ep));
  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    if (pkt === 1'b1) begin
      pkts <= pkts + 1;
      last_ep <= pkt_ep;
    end
    if (irq === 1'b1) begin
      irqs <= irqs + 1;
      clr_ep <= irq_ep;
    end
  end
  task automatic chk(input logic [15:0] g, input logic [15:0] x);
    checks_done++;
    if (g !== x) begin
      num_errors++;
      $display("BAD %0t got %h want %h", $time, g, x);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    sl <= 4'hf;
    we <= w;
    adr <= a;
    dat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) begin
      n++;
      if (n > 40) begin
        num_errors++;
        complete_run();
      end
      @(posedge clk_i);
    end
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    sl <= 4'h0;
    @(posedge clk_i);
  endtask
  task automatic cmd(input logic [7:0] c);
    wb(1'b1, ADR_CMD, {24'h0, c});
  endtask
  task automatic fill(input int e, input int l);
    mem[e][0] = 16'(l);
    cmd(8'(e));
    for (int i = 0; i <= (l + 1) / 2; i++) begin
      if (i > 0) begin
        mem[e][i] = 16'($random(seed));
      end
      wb(1'b1, ADR_DATA, {16'h0, mem[e][i]});
    end
  endtask
  task automatic rback(input int e, input int l);
    cmd(CMD_RD_CTL + 8'(e));
    for (int i = 0; i <= (l + 1) / 2; i++) begin
      mk = (i == (l + 1) / 2 && l % 2 == 1) ? 16'h00ff : 16'hffff;
      wb(1'b0, ADR_DATA, 32'h0);
      chk(q[15:0] & mk, mem[e][i] & mk);
    end
  endtask
  task automatic stat(input logic [7:0] c, input logic [15:0] m,
                      input logic [15:0] x);
    int k;
    cmd(c);
    k = irqs;
    wb(1'b0, ADR_DATA, 32'h0);
    chk(q[15:0] & m, x);
    chk(16'(irqs - k), 16'h0001);
    chk({12'h0, clr_ep}, {12'h0, c[3:0]});
  endtask
  task automatic ev(input int b, input logic v);
    fb <= v;
    evp <= 8'h01 << b;
    @(posedge clk_i);
    evp <= 8'h00;
    @(posedge clk_i);
  endtask
  task automatic pulse(input int b, input logic [15:0] d);
    dma_wd <= d;
    dp <= 3'h1 << b;
    @(posedge clk_i);
    dp <= 3'h0;
    @(posedge clk_i);
  endtask
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(q[15:0], 16'h0000);
    wb(1'b0, 4'hc, 32'h0);
    chk(q[15:0], 16'h0000);
    cmd(CMD_RD_CTL);
    wb(1'b0, ADR_STAT, 32'h0);
    chk(q[15:0], 16'h0200);
    for (int e = 1; e < 16; e++) begin
      nw = (e == 15) ? BULK_MAX_BYTES : 1 + {$random(seed)} % 32;
      fill(e, nw);
      wb(1'b0, ADR_STAT, 32'h0);
      chk(q[15:0], 16'h0100 + 16'((nw + 1) / 2 + 1));
      if (e > 1) begin
        rback(e, nw);
      end
    end
    wb(1'b0, ADR_DATA, 32'h0);
    chk(q[15:0], 16'h0000);
    cmd(CMD_WR_HI);
    wb(1'b0, ADR_DATA, 32'h0);
    chk(q[15:0], 16'h0000);
    // Status flags of the control OUT endpoint
    ev(0, 1'b0);
    ev(6, 1'b1);
    ev(4, 1'b1);
    ev(4, 1'b0);
    stat(CMD_ST_LO, 16'hffff, 16'h00f0);
    ev(1, 1'b0);
    stat(CMD_ST_LO, 16'hffff, 16'h0070);
    ev(0, 1'b0);
    ev(2, 1'b0);
    stat(CMD_ST_LO, 16'hffff, 16'h0074);
    ev(3, 1'b0);
    stat(CMD_ST_LO, 16'hffff, 16'h007c);
    stat(CMD_ST_LO, 16'hffff, 16'h0074);
    ev(5, 1'b0);
    stat(CMD_ST_LO, 16'hffff, 16'h0050);
    ev(0, 1'b0);
    cmd(CMD_RESET);
    stat(CMD_ST_LO, 16'hffff, 16'h0000);
    for (int e = 1; e < 16; e++) begin
      stat(CMD_ST_LO + 8'(e), 16'hff01, 16'h0000);
    end
    // DMA read skips the length word and flags the last one
    fill(5, 7);
    dma_ep <= 4'h5;
    pulse(0, 16'h0000);
    for (int i = 1; i <= 4; i++) begin
      mk = (i == 4) ? 16'h00ff : 16'hffff;
      pulse(2, 16'h0000);
      chk(dma_rdat & mk, mem[5][i] & mk);
      chk({15'h0, dma_last}, 16'(i == 4));
    end
    nw = pkts;
    ev(7, 1'b0);
    repeat (2) @(posedge clk_i);
    chk(16'(pkts - nw), 16'h0001);
    chk({12'h0, last_ep}, 16'h0005);
    dma_ep <= 4'h6;
    pulse(0, 16'h0000);
    for (int i = 1; i <= 2; i++) begin
      mem[6][i] = 16'($random(seed));
      pulse(1, mem[6][i]);
    end
    rback(6, 4);
    // Double-buffered DMA writes run on into the secondary buffer
    dbl <= 16'h0080;
    dma_ep <= 4'h7;
    pulse(0, 16'h0000);
    nw = pkts;
    for (int i = 1; i <= 16; i++) begin
      pulse(1, 16'($random(seed)));
    end
    mem[7][1] = 16'($random(seed));
    pulse(1, mem[7][1]);
    chk(16'(pkts - nw), 16'h0001);
    chk({12'h0, last_ep}, 16'h0007);
    ee <= 4'h7;
    ev(6, 1'b1);
    stat(CMD_ST_LO + 8'h07, 16'hffff, 16'h0032);
    pulse(0, 16'h0000);
    pulse(2, 16'h0000);
    chk(dma_rdat, mem[7][1]);
    complete_run();
  end
endmodule // uebc_bench
`default_nettype wire
